/* core/drive_stop_reaction_select.sv */
/*
  Drive stop reaction select: holds the stop selection objects and the
  speed scaling factor, and tells the ramp generators and the power state
  machine how to stop for quick stop, shutdown, disable, halt and fault.
  Assumes the power state machine raises one-cycle trigger pulses and
  reports standstill; objects are written over an index/subindex port.
*/
`timescale 1ns/1ps
module drive_stop_reaction_select #(
  parameter int DATA_WIDTH = 32
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic objWrite,
  input wire logic objRead,
  input wire logic [15:0] objIndex,
  input wire logic [7:0] objSubindex,
  input wire logic [DATA_WIDTH-1:0] objWriteData,
  output logic [DATA_WIDTH-1:0] objReadData,
  output logic objAck,
  output logic objError,
  input wire logic [15:0] controlword,
  input wire logic quickStopRequest,
  input wire logic shutdownRequest,
  input wire logic disableRequest,
  input wire logic faultRequest,
  input wire logic enableRequest,
  input wire logic motorStandstill,
  input wire logic signed [DATA_WIDTH-1:0] speedInternal,
  output logic signed [DATA_WIDTH-1:0] speedRpm,
  output dsr_pkg::dsr_brake_t brakeMode,
  output logic torqueEnable,
  output logic stopDone,
  output dsr_pkg::dsr_next_t nextPowerState,
  output logic reservedCode
);
  logic signed [31:0] numerator;
  logic signed [31:0] denominator;
  logic signed [15:0] quickStopSel;
  logic signed [15:0] shutdownSel;
  logic signed [15:0] disableSel;
  logic signed [15:0] haltSel;
  logic signed [15:0] faultSel;
  logic signed [31:0] next_numerator;
  logic signed [31:0] next_denominator;
  logic signed [15:0] next_quickStopSel;
  logic signed [15:0] next_shutdownSel;
  logic signed [15:0] next_disableSel;
  logic signed [15:0] next_haltSel;
  logic signed [15:0] next_faultSel;
  logic [DATA_WIDTH-1:0] next_objReadData;
  logic next_objAck;
  logic next_objError;

  dsr_pkg::dsr_state_t state;
  dsr_pkg::dsr_state_t next_state;
  dsr_pkg::dsr_brake_t next_brakeMode;
  dsr_pkg::dsr_next_t next_nextPowerState;
  dsr_pkg::dsr_next_t target;
  dsr_pkg::dsr_next_t next_target;
  logic next_torqueEnable;
  logic next_stopDone;
  logic next_reservedCode;
  logic haltActive;

  dsr_speed_scale #(
    .WIDTH(DATA_WIDTH)
  ) speedScale (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .speedInternal(speedInternal),
    .numerator(numerator),
    .denominator(denominator),
    .speedRpm(speedRpm)
  );

  // Object access; every access answers the next cycle
  always_comb begin
    next_numerator = numerator;
    next_denominator = denominator;
    next_quickStopSel = quickStopSel;
    next_shutdownSel = shutdownSel;
    next_disableSel = disableSel;
    next_haltSel = haltSel;
    next_faultSel = faultSel;
    next_objReadData = objReadData;
    next_objAck = objWrite | objRead;
    next_objError = 1'b0;
    if (objWrite) begin
      unique case (objIndex)
        dsr_pkg::IDX_SPEED_SCALE: begin
          if (objSubindex == dsr_pkg::SUB_NUMERATOR) begin
            next_numerator = objWriteData[31:0];
          end else if (objSubindex == dsr_pkg::SUB_DENOMINATOR) begin
            next_denominator = objWriteData[31:0];
          end else begin
            next_objError = 1'b1;
          end
        end
        dsr_pkg::IDX_QUICK_STOP: next_quickStopSel = objWriteData[15:0];
        dsr_pkg::IDX_SHUTDOWN: next_shutdownSel = objWriteData[15:0];
        dsr_pkg::IDX_DISABLE: next_disableSel = objWriteData[15:0];
        dsr_pkg::IDX_HALT: next_haltSel = objWriteData[15:0];
        dsr_pkg::IDX_FAULT: next_faultSel = objWriteData[15:0];
        default: next_objError = 1'b1;
      endcase
    end else if (objRead) begin
      next_objReadData = '0;
      unique case (objIndex)
        dsr_pkg::IDX_SPEED_SCALE: begin
          if (objSubindex == dsr_pkg::SUB_COUNT) begin
            next_objReadData = {{(DATA_WIDTH-8){1'b0}}, dsr_pkg::RST_ENTRY_COUNT};
          end else if (objSubindex == dsr_pkg::SUB_NUMERATOR) begin
            next_objReadData = numerator;
          end else if (objSubindex == dsr_pkg::SUB_DENOMINATOR) begin
            next_objReadData = denominator;
          end else begin
            next_objError = 1'b1;
          end
        end
        // 16-bit objects read sign-extended
        dsr_pkg::IDX_QUICK_STOP: next_objReadData = {{16{quickStopSel[15]}}, quickStopSel};
        dsr_pkg::IDX_SHUTDOWN: next_objReadData = {{16{shutdownSel[15]}}, shutdownSel};
        dsr_pkg::IDX_DISABLE: next_objReadData = {{16{disableSel[15]}}, disableSel};
        dsr_pkg::IDX_HALT: next_objReadData = {{16{haltSel[15]}}, haltSel};
        dsr_pkg::IDX_FAULT: next_objReadData = {{16{faultSel[15]}}, faultSel};
        default: next_objError = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      numerator <= dsr_pkg::RST_NUMERATOR;
      denominator <= dsr_pkg::RST_DENOMINATOR;
      quickStopSel <= dsr_pkg::RST_QUICK_STOP;
      shutdownSel <= dsr_pkg::RST_SHUTDOWN;
      disableSel <= dsr_pkg::RST_DISABLE;
      haltSel <= dsr_pkg::RST_HALT;
      faultSel <= dsr_pkg::RST_FAULT;
      objReadData <= '0;
      objAck <= 1'b0;
      objError <= 1'b0;
    end else begin
      numerator <= next_numerator;
      denominator <= next_denominator;
      quickStopSel <= next_quickStopSel;
      shutdownSel <= next_shutdownSel;
      disableSel <= next_disableSel;
      haltSel <= next_haltSel;
      faultSel <= next_faultSel;
      objReadData <= next_objReadData;
      objAck <= next_objAck;
      objError <= next_objError;
    end
  end

  assign haltActive = controlword[dsr_pkg::HALT_BIT];

  // Stop sequencer; fault beats quick stop beats disable beats shutdown
  always_comb begin
    next_state = state;
    next_brakeMode = brakeMode;
    next_target = target;
    next_nextPowerState = dsr_pkg::NEXT_NONE;
    next_torqueEnable = torqueEnable;
    next_stopDone = 1'b0;
    next_reservedCode = reservedCode;
    unique case (state)
      dsr_pkg::ST_IDLE: begin
        next_torqueEnable = 1'b1;
        next_reservedCode = 1'b0;
        if (faultRequest) begin
          next_target = dsr_pkg::NEXT_FAULT;
          if (faultSel == dsr_pkg::CODE_0) begin
            next_brakeMode = dsr_pkg::BRAKE_NONE;
            next_torqueEnable = 1'b0;
            next_state = dsr_pkg::ST_COAST;
          end else if (faultSel == dsr_pkg::CODE_1) begin
            next_brakeMode = dsr_pkg::BRAKE_MODE_RAMP;
            next_state = dsr_pkg::ST_BRAKE;
          end else begin
            // Reserved treated as quick stop ramp, the safer choice
            next_reservedCode = (faultSel != dsr_pkg::CODE_2);
            next_brakeMode = dsr_pkg::BRAKE_QS_RAMP;
            next_state = dsr_pkg::ST_BRAKE;
          end
        end else if (quickStopRequest) begin
          next_target = dsr_pkg::NEXT_SWITCH_ON_DISABLED;
          next_state = dsr_pkg::ST_BRAKE;
          if (quickStopSel == dsr_pkg::CODE_0) begin
            next_brakeMode = dsr_pkg::BRAKE_IMMEDIATE;
          end else if (quickStopSel == dsr_pkg::CODE_1) begin
            next_brakeMode = dsr_pkg::BRAKE_MODE_RAMP;
          end else if (quickStopSel == dsr_pkg::CODE_5) begin
            next_brakeMode = dsr_pkg::BRAKE_MODE_RAMP;
            next_target = dsr_pkg::NEXT_QUICK_STOP_ACTIVE;
          end else if (quickStopSel == dsr_pkg::CODE_6) begin
            next_brakeMode = dsr_pkg::BRAKE_QS_RAMP;
            next_target = dsr_pkg::NEXT_QUICK_STOP_ACTIVE;
          end else begin
            // quick stop ramp; reserved codes fall here too
            next_reservedCode = (quickStopSel != dsr_pkg::CODE_2);
            next_brakeMode = dsr_pkg::BRAKE_QS_RAMP;
          end
        end else if (disableRequest || shutdownRequest) begin
          next_target = disableRequest ? dsr_pkg::NEXT_SWITCHED_ON
                                       : dsr_pkg::NEXT_READY_TO_SWITCH_ON;
          if ((disableRequest ? disableSel : shutdownSel) == dsr_pkg::CODE_0) begin
            next_brakeMode = dsr_pkg::BRAKE_NONE;
            next_torqueEnable = 1'b0;
            next_state = dsr_pkg::ST_COAST;
          end else begin
            next_reservedCode =
              ((disableRequest ? disableSel : shutdownSel) != dsr_pkg::CODE_1);
            next_brakeMode = dsr_pkg::BRAKE_MODE_RAMP;
            next_state = dsr_pkg::ST_BRAKE;
          end
        end else if (haltActive) begin
          next_reservedCode = (haltSel != dsr_pkg::CODE_1) && (haltSel != dsr_pkg::CODE_2);
          next_brakeMode = (haltSel == dsr_pkg::CODE_2) ? dsr_pkg::BRAKE_QS_RAMP
                                                       : dsr_pkg::BRAKE_MODE_RAMP;
        end else begin
          next_brakeMode = dsr_pkg::BRAKE_NONE;
        end
      end
      dsr_pkg::ST_BRAKE: begin
        if (motorStandstill) begin
          next_brakeMode = dsr_pkg::BRAKE_NONE;
          next_state = (target == dsr_pkg::NEXT_QUICK_STOP_ACTIVE) ? dsr_pkg::ST_HOLD
                                                                   : dsr_pkg::ST_DONE;
          // Torque stays on while held in quick stop
          next_torqueEnable = (target == dsr_pkg::NEXT_QUICK_STOP_ACTIVE);
        end
      end
      dsr_pkg::ST_COAST: begin
        // Torque already off; standstill not awaited
        next_state = dsr_pkg::ST_DONE;
      end
      dsr_pkg::ST_HOLD: begin
        if (enableRequest) begin
          next_state = dsr_pkg::ST_IDLE;
        end else begin
          // Stop reported while held; drops with the state, not a cycle late
          next_stopDone = 1'b1;
          next_nextPowerState = dsr_pkg::NEXT_QUICK_STOP_ACTIVE;
        end
      end
      dsr_pkg::ST_DONE: begin
        next_torqueEnable = 1'b0;
        if (enableRequest) begin
          next_state = dsr_pkg::ST_IDLE;
        end else begin
          next_stopDone = 1'b1;
          next_nextPowerState = target;
        end
      end
      default: begin
        next_state = dsr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= dsr_pkg::ST_IDLE;
      brakeMode <= dsr_pkg::BRAKE_NONE;
      target <= dsr_pkg::NEXT_NONE;
      nextPowerState <= dsr_pkg::NEXT_NONE;
      torqueEnable <= 1'b0;
      stopDone <= 1'b0;
      reservedCode <= 1'b0;
    end else begin
      state <= next_state;
      brakeMode <= next_brakeMode;
      target <= next_target;
      nextPowerState <= next_nextPowerState;
      torqueEnable <= next_torqueEnable;
      stopDone <= next_stopDone;
      reservedCode <= next_reservedCode;
    end
  end
endmodule

/* common/dsr_pkg.sv */
/*
  Package for the drive stop reaction select block: object indices,
  subindices, reset values, reaction codes and controller states.
  Assumes an object-dictionary style access port (index, subindex, data).
*/
package dsr_pkg;
  localparam logic [15:0] IDX_SPEED_SCALE = 16'h604C;
  localparam logic [15:0] IDX_QUICK_STOP = 16'h605A;
  localparam logic [15:0] IDX_SHUTDOWN = 16'h605B;
  localparam logic [15:0] IDX_DISABLE = 16'h605C;
  localparam logic [15:0] IDX_HALT = 16'h605D;
  localparam logic [15:0] IDX_FAULT = 16'h605E;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_NUMERATOR = 8'h01;
  localparam logic [7:0] SUB_DENOMINATOR = 8'h02;

  localparam logic [7:0] RST_ENTRY_COUNT = 8'h02;
  localparam logic [31:0] RST_NUMERATOR = 32'h00000001;
  localparam logic [31:0] RST_DENOMINATOR = 32'h00000001;
  localparam logic [15:0] RST_QUICK_STOP = 16'h0002;
  localparam logic [15:0] RST_SHUTDOWN = 16'h0001;
  localparam logic [15:0] RST_DISABLE = 16'h0001;
  localparam logic [15:0] RST_HALT = 16'h0001;
  localparam logic [15:0] RST_FAULT = 16'h0002;

  // Reaction codes of the selection objects; only CODE_1 is used by all of them
  localparam logic [15:0] CODE_0 = 16'h0000;
  localparam logic [15:0] CODE_1 = 16'h0001;
  localparam logic [15:0] CODE_2 = 16'h0002;
  localparam logic [15:0] CODE_5 = 16'h0005;
  localparam logic [15:0] CODE_6 = 16'h0006;

  localparam int HALT_BIT = 8;

  // Braking method presented to the ramp generators
  typedef enum logic [1:0] {
    BRAKE_NONE = 2'h0,
    BRAKE_MODE_RAMP = 2'h1,
    BRAKE_QS_RAMP = 2'h2,
    BRAKE_IMMEDIATE = 2'h3
  } dsr_brake_t;

  // Power state that follows the stop
  typedef enum logic [2:0] {
    NEXT_NONE = 3'h0,
    NEXT_SWITCH_ON_DISABLED = 3'h1,
    NEXT_READY_TO_SWITCH_ON = 3'h2,
    NEXT_SWITCHED_ON = 3'h3,
    NEXT_QUICK_STOP_ACTIVE = 3'h4,
    NEXT_FAULT = 3'h5
  } dsr_next_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_BRAKE = 5'b00010,
    ST_HOLD = 5'b00100,
    ST_COAST = 5'b01000,
    ST_DONE = 5'b10000
  } dsr_state_t;
endpackage

/* core/dsr_speed_scale.sv */
/*
  Speed scaling: internal speed times numerator, divided by denominator.
  Assumes numerator and denominator come from the register file on the
  same clock; a zero denominator yields zero.
*/
`timescale 1ns/1ps
module dsr_speed_scale #(
  parameter int WIDTH = 32
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic signed [WIDTH-1:0] speedInternal,
  input wire logic signed [WIDTH-1:0] numerator,
  input wire logic signed [WIDTH-1:0] denominator,
  output logic signed [WIDTH-1:0] speedRpm
);
  logic signed [2*WIDTH-1:0] product;
  logic signed [2*WIDTH-1:0] quotient;
  logic signed [WIDTH-1:0] next_speedRpm;

  always_comb begin
    product = (2*WIDTH)'(speedInternal) * (2*WIDTH)'(numerator);
    // Zero guard: divide by zero would give X in simulation
    if (denominator == '0) begin
      quotient = '0;
    end else begin
      quotient = product / (2*WIDTH)'(denominator);
    end
    next_speedRpm = quotient[WIDTH-1:0];
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      speedRpm <= '0;
    end else begin
      speedRpm <= next_speedRpm;
    end
  end
endmodule

/* verif/dsr_asserts.sv */
/* Checker for the stop reaction select ports.
   Assumes it is bound to every drive_stop_reaction_select instance. */
`timescale 1ns/1ps
module dsr_asserts (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic objWrite,
  input wire logic objRead,
  input wire logic [15:0] objIndex,
  input wire logic [7:0] objSubindex,
  input wire logic objAck,
  input wire logic objError,
  input wire logic enableRequest,
  input wire dsr_pkg::dsr_brake_t brakeMode,
  input wire logic torqueEnable,
  input wire logic stopDone,
  input wire dsr_pkg::dsr_next_t nextPowerState
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_ack_follows: assert property ((objWrite || objRead) |=> objAck)
    else $error("access without acknowledge");
  a_ack_cause: assert property (objAck |-> $past(objWrite || objRead))
    else $error("acknowledge without access");
  a_error_acked: assert property (objError |-> objAck)
    else $error("error without acknowledge");
  a_count_readonly: assert property (objWrite && objIndex == dsr_pkg::IDX_SPEED_SCALE
    && objSubindex == dsr_pkg::SUB_COUNT |=> objError)
    else $error("entry count write not refused");
  a_done_stands: assert property (stopDone && !enableRequest |=> stopDone)
    else $error("done left without enable");
  a_done_target: assert property (stopDone |-> nextPowerState != dsr_pkg::NEXT_NONE)
    else $error("done without target state");
  a_done_braked: assert property (stopDone |-> brakeMode == dsr_pkg::BRAKE_NONE)
    else $error("braking still active at done");
  a_qsa_energized: assert property (stopDone
    && nextPowerState == dsr_pkg::NEXT_QUICK_STOP_ACTIVE |-> torqueEnable)
    else $error("quick stop active without torque");
  a_sod_off: assert property (stopDone
    && nextPowerState == dsr_pkg::NEXT_SWITCH_ON_DISABLED |-> !torqueEnable)
    else $error("switch on disabled with torque");
  c_qsa: cover property (stopDone && nextPowerState == dsr_pkg::NEXT_QUICK_STOP_ACTIVE);
  c_fault: cover property (stopDone && nextPowerState == dsr_pkg::NEXT_FAULT);
  c_refused: cover property (objError);
endmodule

bind drive_stop_reaction_select dsr_asserts chk (.clk_sys, .reset_n, .objWrite, .objRead,
  .objIndex, .objSubindex, .objAck, .objError, .enableRequest, .brakeMode, .torqueEnable,
  .stopDone, .nextPowerState);

/* verif/dsr_master_model.sv */
/* Fieldbus master model: object writes and reads on the access port.
   Assumes the bench calls xfer; drives on the falling edge. */
`timescale 1ns/1ps
module dsr_master_model (
  input wire logic clk_sys,
  output logic objWrite,
  output logic objRead,
  output logic [15:0] objIndex,
  output logic [7:0] objSubindex,
  output logic [31:0] objWriteData,
  input wire logic [31:0] objReadData,
  input wire logic objAck,
  input wire logic objError
);
  initial begin
    objWrite = 1'b0;
    objRead = 1'b0;
    objIndex = 16'h0000;
    objSubindex = 8'h00;
    objWriteData = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s,
      input logic [31:0] d, output logic [31:0] rd, output logic er, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h00000000;
    er = 1'b0;
    @(negedge clk_sys);
    objWrite = w;
    objRead = !w;
    objIndex = i;
    objSubindex = s;
    objWriteData = d;
    @(negedge clk_sys);
    objWrite = 1'b0;
    objRead = 1'b0;
    // Released lines inverted so stale values never look valid
    objIndex = ~i;
    objSubindex = ~s;
    objWriteData = ~d;
    for (n = 0; n < 4 && !ok; n++) begin
      if (objAck === 1'b1) begin
        ok = 1'b1;
        rd = objReadData;
        er = objError;
      end else @(negedge clk_sys);
    end
  endtask
endmodule

/* verif/tb_top.sv */
/* Bench for the stop reaction select block: objects, speed, stops.
   Assumes the master model for object access and a 200 MHz clock. */
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic objWrite, objRead, objAck, objError, torqueEnable, stopDone, reservedCode, er, ok;
  logic quickStopRequest, shutdownRequest, disableRequest, faultRequest;
  logic enableRequest, motorStandstill;
  logic [15:0] objIndex, controlword;
  logic [7:0] objSubindex;
  logic [31:0] objWriteData, objReadData, rd;
  logic signed [31:0] speedInternal, speedRpm;
  dsr_pkg::dsr_brake_t brakeMode;
  dsr_pkg::dsr_next_t nextPowerState;
  int badCount = 0;
  int compares = 0;
  int c;
  always #2.5 clk_sys = ~clk_sys;
  dsr_master_model mst (.clk_sys, .objWrite, .objRead, .objIndex, .objSubindex,
    .objWriteData, .objReadData, .objAck, .objError);
  drive_stop_reaction_select DUT (.clk_sys, .reset_n, .objWrite, .objRead, .objIndex,
    .objSubindex, .objWriteData, .objReadData, .objAck, .objError, .controlword,
    .quickStopRequest, .shutdownRequest, .disableRequest, .faultRequest, .enableRequest,
    .motorStandstill, .speedInternal, .speedRpm, .brakeMode, .torqueEnable, .stopDone,
    .nextPowerState, .reservedCode);

  task automatic endSim();
    $display("compares=%0d mismatches=%0d", compares, badCount);
    if (badCount == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkFlag(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // Read checks data d unless refused; write only checks the error flag
  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
      input logic [31:0] d, input logic e);
    mst.xfer(w, i, s, d, rd, er, ok);
    if (ok !== 1'b1) begin
      badCount++;
      endSim();
    end
    chkFlag(er, e);
    if (!w && !e) chk(rd, d);
  endtask
  // Trigger bits: fault, quick stop, disable, shutdown
  task automatic stopCase(input logic [3:0] t, input logic [15:0] i, input logic [15:0] code,
      input int br, input int nx, input logic tq, input logic rs);
    int n;
    acc(1'b1, i, 8'h00, {16'h0000, code}, 1'b0);
    @(negedge clk_sys);
    {faultRequest, quickStopRequest, disableRequest, shutdownRequest} = t;
    @(negedge clk_sys);
    {faultRequest, quickStopRequest, disableRequest, shutdownRequest} = 4'h0;
    chk(32'(brakeMode), 32'(br));
    chkFlag(reservedCode, rs);
    motorStandstill = 1'b1;
    for (n = 0; n < 8 && stopDone !== 1'b1; n++) @(negedge clk_sys);
    if (stopDone !== 1'b1) begin
      badCount++;
      endSim();
    end
    chk(32'(nextPowerState), 32'(nx));
    chkFlag(torqueEnable, tq);
    enableRequest = 1'b1;
    @(negedge clk_sys);
    enableRequest = 1'b0;
    motorStandstill = 1'b0;
    repeat (2) @(negedge clk_sys);
    $display("stop test done: object %h code %h", i, code);
  endtask

  initial begin
    {quickStopRequest, shutdownRequest, disableRequest, faultRequest} = 4'h0;
    {enableRequest, motorStandstill} = 2'b00;
    controlword = 16'h0000;
    speedInternal = 32'sh00000000;
    repeat (8) @(negedge clk_sys);
    reset_n = 1'b1;
    acc(1'b0, dsr_pkg::IDX_SPEED_SCALE, 8'h00, 32'h00000002, 1'b0);
    acc(1'b0, dsr_pkg::IDX_SPEED_SCALE, 8'h01, 32'h00000001, 1'b0);
    acc(1'b0, dsr_pkg::IDX_SPEED_SCALE, 8'h02, 32'h00000001, 1'b0);
    acc(1'b0, dsr_pkg::IDX_QUICK_STOP, 8'h00, 32'h00000002, 1'b0);
    acc(1'b0, dsr_pkg::IDX_SHUTDOWN, 8'h00, 32'h00000001, 1'b0);
    acc(1'b0, dsr_pkg::IDX_DISABLE, 8'h00, 32'h00000001, 1'b0);
    acc(1'b0, dsr_pkg::IDX_HALT, 8'h00, 32'h00000001, 1'b0);
    acc(1'b0, dsr_pkg::IDX_FAULT, 8'h00, 32'h00000002, 1'b0);
    acc(1'b1, dsr_pkg::IDX_SPEED_SCALE, 8'h00, 32'h00000005, 1'b1);
    acc(1'b0, dsr_pkg::IDX_SPEED_SCALE, 8'h00, 32'h00000002, 1'b0);
    acc(1'b0, 16'h6060, 8'h00, 32'h00000000, 1'b1);
    acc(1'b1, dsr_pkg::IDX_HALT, 8'h00, 32'h0000FFFF, 1'b0);
    acc(1'b0, dsr_pkg::IDX_HALT, 8'h00, 32'hFFFFFFFF, 1'b0);
    $display("object test done");
    acc(1'b1, dsr_pkg::IDX_SPEED_SCALE, 8'h01, 32'h0000003C, 1'b0);
    speedInternal = 32'sh00000005;
    repeat (2) @(negedge clk_sys);
    chk(speedRpm, 32'h0000012C);
    acc(1'b1, dsr_pkg::IDX_SPEED_SCALE, 8'h01, 32'hFFFFFFFD, 1'b0);
    acc(1'b1, dsr_pkg::IDX_SPEED_SCALE, 8'h02, 32'h00000002, 1'b0);
    acc(1'b0, dsr_pkg::IDX_SPEED_SCALE, 8'h01, 32'hFFFFFFFD, 1'b0);
    speedInternal = 32'sh00000007;
    repeat (2) @(negedge clk_sys);
    chk(speedRpm, 32'hFFFFFFF6);
    $display("speed test done");
    for (c = 1; c <= 2; c++) begin
      acc(1'b1, dsr_pkg::IDX_HALT, 8'h00, 32'(c), 1'b0);
      controlword = 16'h0100;
      @(negedge clk_sys);
      chk(32'(brakeMode), 32'(c));
      controlword = 16'h0000;
      repeat (2) @(negedge clk_sys);
    end
    $display("halt test done");
    stopCase(4'h4, dsr_pkg::IDX_QUICK_STOP, 16'h0000, 3, 1, 1'b0, 1'b0);
    stopCase(4'h4, dsr_pkg::IDX_QUICK_STOP, 16'h0001, 1, 1, 1'b0, 1'b0);
    stopCase(4'h4, dsr_pkg::IDX_QUICK_STOP, 16'h0002, 2, 1, 1'b0, 1'b0);
    stopCase(4'h4, dsr_pkg::IDX_QUICK_STOP, 16'h0005, 1, 4, 1'b1, 1'b0);
    stopCase(4'h4, dsr_pkg::IDX_QUICK_STOP, 16'h0006, 2, 4, 1'b1, 1'b0);
    stopCase(4'h4, dsr_pkg::IDX_QUICK_STOP, 16'h0003, 2, 1, 1'b0, 1'b1);
    stopCase(4'h1, dsr_pkg::IDX_SHUTDOWN, 16'h0001, 1, 2, 1'b0, 1'b0);
    stopCase(4'h1, dsr_pkg::IDX_SHUTDOWN, 16'h0000, 0, 2, 1'b0, 1'b0);
    stopCase(4'h2, dsr_pkg::IDX_DISABLE, 16'h0001, 1, 3, 1'b0, 1'b0);
    stopCase(4'h2, dsr_pkg::IDX_DISABLE, 16'h0000, 0, 3, 1'b0, 1'b0);
    stopCase(4'h8, dsr_pkg::IDX_FAULT, 16'h0000, 0, 5, 1'b0, 1'b0);
    stopCase(4'h8, dsr_pkg::IDX_FAULT, 16'h0002, 2, 5, 1'b0, 1'b0);
    stopCase(4'hC, dsr_pkg::IDX_FAULT, 16'h0001, 1, 5, 1'b0, 1'b0);
    endSim();
  end
endmodule
